//--- src/ubsc_top.sv
// Purpose: suspend state, suspend indicators, reset pin and modem pin control
// Assumes: usb core events are one-cycle pulses synchronous to I_SYS_CLK
// Notes:   indicators are released (not driven) while the device is in reset
module ubsc_top
   import ubsc_pkg::*;
#(
   parameter int unsigned EXT_RST_CYC = EXT_RST_MIN_CYC
)(
   input  wire logic                      I_SYS_CLK,
   input  wire logic                      I_RSTN,
   input  wire logic                      I_RST_PIN,
   input  wire logic                      I_POR,
   input  wire logic                      I_VBUS,
   input  wire ubsc_pkg::ubsc_usb_evt_t   I_USB_EVT,
   input  wire ubsc_pkg::ubsc_modem_in_t  I_MODEM,
   input  wire logic                      I_RTS_REQ,
   input  wire logic                      I_DTR_REQ,
   output logic                           O_RST_PIN,
   output logic                           O_RST_PIN_OE,
   output logic                           O_SUSP,
   output logic                           O_SUSP_OE,
   output logic                           O_SUSP_N,
   output logic                           O_SUSP_N_OE,
   output logic                           O_RTS_N,
   output logic                           O_DTR_N,
   output logic                           O_VBUS_ATTACHED,
   output logic                           O_DEV_RST,
   output ubsc_pkg::ubsc_modem_stat_t     O_MODEM_STAT
);
   import ubsc_pkg::*;

   if (EXT_RST_CYC < 1)
   begin : g_bad_ext_rst_cyc
      $error("ubsc_top: EXT_RST_CYC must be at least 1");
   end

   // ************************************************************
   // reset pin qualification and open-drain drive
   // ************************************************************
   logic ext_rst;
   logic drive_low;

   ubsc_rst_filt #(
      .MIN_CYC     (EXT_RST_CYC)
   ) u_rst_filt (
      .I_SYS_CLK   (I_SYS_CLK),
      .I_RSTN      (I_RSTN),
      .i_pin_lvl   (I_RST_PIN),
      .i_por       (I_POR),
      .o_ext_rst   (ext_rst),
      .o_drive_low (drive_low)
   );

   // pin data stays low; enable alone pulls the line
   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RSTN)
      begin
         O_RST_PIN    <= 1'b0;
         O_RST_PIN_OE <= 1'b0;
      end
      else
      begin
         O_RST_PIN    <= 1'b0;
         O_RST_PIN_OE <= drive_low;
      end
   end

   // device-level reset seen by the rest of the chip
   logic dev_rst;
   assign dev_rst = ext_rst || drive_low;

   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RSTN)
         O_DEV_RST <= 1'b1;
      else
         O_DEV_RST <= dev_rst;
   end

   // ************************************************************
   // vbus sense
   // ************************************************************
   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RSTN)
         O_VBUS_ATTACHED <= 1'b0;
      else
         O_VBUS_ATTACHED <= I_VBUS;
   end

   // ************************************************************
   // suspend state
   // ************************************************************
   ubsc_state_t state_q;
   ubsc_state_t state_d;
   logic        leave;

   // resume, bus reset: both beat a suspend in the same cycle
   assign leave = I_USB_EVT.resume_det || I_USB_EVT.resume_gen || I_USB_EVT.bus_reset;

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         UBSC_UNCONF:
         begin
            if (I_USB_EVT.configured)
               state_d = UBSC_ACTIVE;
         end
         UBSC_ACTIVE:
         begin
            if (I_USB_EVT.bus_reset)
               state_d = UBSC_UNCONF;
            else if (I_USB_EVT.suspend_det && !leave)
               state_d = UBSC_SUSP;
         end
         UBSC_SUSP:
         begin
            // a bus reset also ends suspend, back to active with the indicators driven and deasserted
            if (leave)
               state_d = UBSC_ACTIVE;
         end
         default:
            state_d = UBSC_UNCONF;
      endcase
   end

   // a device reset always drops back to the unconfigured state
   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RSTN || dev_rst)
         state_q <= UBSC_UNCONF;
      else
         state_q <= state_d;
   end

   // ************************************************************
   // suspend indicators
   // ************************************************************
   logic susp_asrt;
   assign susp_asrt = (state_d != UBSC_ACTIVE);

   // both pins update from one term so they can never skew
   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RSTN || dev_rst)
      begin
         O_SUSP_OE   <= 1'b0;
         O_SUSP_N_OE <= 1'b0;
         O_SUSP      <= 1'b1;
         O_SUSP_N    <= 1'b0;
      end
      else
      begin
         O_SUSP_OE   <= 1'b1;
         O_SUSP_N_OE <= 1'b1;
         O_SUSP      <= susp_asrt;
         O_SUSP_N    <= !susp_asrt;
      end
   end

   // ************************************************************
   // modem control lines
   // ************************************************************
   // inverted here so the usb core only ever sees true levels
   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RSTN)
      begin
         O_RTS_N      <= RTS_IDLE_PIN;
         O_DTR_N      <= DTR_IDLE_PIN;
         O_MODEM_STAT <= '0;
      end
      else
      begin
         O_RTS_N          <= !I_RTS_REQ;
         O_DTR_N          <= !I_DTR_REQ;
         O_MODEM_STAT.cts <= !I_MODEM.cts_n;
         O_MODEM_STAT.dsr <= !I_MODEM.dsr_n;
         O_MODEM_STAT.dcd <= !I_MODEM.dcd_n;
         O_MODEM_STAT.ri  <= !I_MODEM.ri_n;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_susp_enter;
      @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      (state_q == UBSC_ACTIVE && I_USB_EVT.suspend_det && !leave && !dev_rst)
         |=> (O_SUSP && !O_SUSP_N && O_SUSP_OE);
   endproperty
   a_susp_enter: assert property (p_susp_enter)
      else $error("suspend entry did not assert indicators");

   property p_susp_go;
      @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      (state_q == UBSC_ACTIVE && I_USB_EVT.suspend_det && !leave && !dev_rst)
         |=> state_q == UBSC_SUSP;
   endproperty
   a_susp_go: assert property (p_susp_go)
      else $error("suspend signalling ignored");

   property p_unconf_asrt;
      @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      (O_SUSP_OE && state_q == UBSC_UNCONF) |-> O_SUSP;
   endproperty
   a_unconf_asrt: assert property (p_unconf_asrt)
      else $error("indicator released before configuration");

   property p_resume_exit;
      @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      (state_q == UBSC_SUSP && (I_USB_EVT.resume_det || I_USB_EVT.resume_gen)
       && !I_USB_EVT.bus_reset && !dev_rst) |=> state_q == UBSC_ACTIVE;
   endproperty
   a_resume_exit: assert property (p_resume_exit)
      else $error("resume did not leave suspend");

   property p_exit_deassert;
      @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      (state_q == UBSC_SUSP && leave && !dev_rst)
         |=> (!O_SUSP && O_SUSP_N);
   endproperty
   a_exit_deassert: assert property (p_exit_deassert)
      else $error("indicators not deasserted on exit");

   property p_float_rst;
      @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      dev_rst |=> (!O_SUSP_OE && !O_SUSP_N_OE && state_q == UBSC_UNCONF);
   endproperty
   a_float_rst: assert property (p_float_rst)
      else $error("indicators driven during device reset");

   property p_compl;
      @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      (O_SUSP_OE == O_SUSP_N_OE) && (!O_SUSP_OE || (O_SUSP != O_SUSP_N));
   endproperty
   a_compl: assert property (p_compl)
      else $error("indicators not complementary");

   property p_rst_od;
      @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      ##1 (!O_RST_PIN && (O_RST_PIN_OE == $past(I_POR, 2)));
   endproperty
   a_rst_od: assert property (p_rst_od)
      else $error("reset pin not open drain from power-on");

   property p_vbus;
      @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      ##1 O_VBUS_ATTACHED == $past(I_VBUS);
   endproperty
   a_vbus: assert property (p_vbus)
      else $error("vbus sense mismatch");

   property p_modem;
      @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      ##1 (O_RTS_N == !$past(I_RTS_REQ)) && (O_MODEM_STAT.cts == !$past(I_MODEM.cts_n));
   endproperty
   a_modem: assert property (p_modem)
      else $error("modem polarity wrong");

   property p_modem_rest;
      @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      ##1 (O_DTR_N == !$past(I_DTR_REQ)) && (O_MODEM_STAT.dsr == !$past(I_MODEM.dsr_n))
         && (O_MODEM_STAT.dcd == !$past(I_MODEM.dcd_n))
         && (O_MODEM_STAT.ri == !$past(I_MODEM.ri_n));
   endproperty
   a_modem_rest: assert property (p_modem_rest)
      else $error("modem polarity wrong on remaining lines");

   property p_cfg_release;
      @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      (state_q == UBSC_UNCONF && I_USB_EVT.configured && !dev_rst)
         |=> (!O_SUSP && O_SUSP_N && O_SUSP_OE);
   endproperty
   a_cfg_release: assert property (p_cfg_release)
      else $error("indicators not released on configuration");

   property p_unconf_hold;
      @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      (state_q == UBSC_UNCONF && !I_USB_EVT.configured)
         |=> state_q == UBSC_UNCONF;
   endproperty
   a_unconf_hold: assert property (p_unconf_hold)
      else $error("left unconfigured state without configuration");

   property p_busrst_exit;
      @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      (state_q == UBSC_SUSP && I_USB_EVT.bus_reset && !dev_rst)
         |=> state_q == UBSC_ACTIVE;
   endproperty
   a_busrst_exit: assert property (p_busrst_exit)
      else $error("bus reset did not leave suspend");

   property p_dev_rst_out;
      @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      dev_rst |=> O_DEV_RST;
   endproperty
   a_dev_rst_out: assert property (p_dev_rst_out)
      else $error("device reset not reported");

endmodule // ubsc_top

//--- src/ubsc_pkg.sv
// Purpose: shared constants and types for the bridge suspend and pin control block
// Assumes: one 125 MHz clock, synchronous active-low reset
// Notes:   all pin levels are given as raw pin levels unless named otherwise
//
// Overview of operation
// - Device drives its reset pin open-drain only, low on power-on or supply fault (there is no supply-fault input; only I_POR pulls it low).
// - A high VBUS sense means a USB network is attached; low means detached.
// - Modem lines are active low: four inputs, two outputs driven by device.
// - Entering suspend drives the high indicator high and the low indicator low.
// - Device enters suspend when the host signals suspend on the bus while configured, unless resume or bus reset comes in the same cycle.
// - After any device reset both indicators stay asserted until configured.
// - Suspend ends on resume, USB bus reset, or device reset.
// - Leaving suspend deasserts both suspend indicators.
// - While held in reset the device does not drive either indicator.
// - Function logic carries data and serves serial-port control requests.
package ubsc_pkg;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int unsigned CLK_PERIOD_PS    = 8000;
   localparam int unsigned EXT_RST_MIN_NS   = 15000;
   localparam int unsigned EXT_RST_MIN_CYC  =
      (EXT_RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned RST_CNT_W        = 12;
   localparam int unsigned SYNC_STAGES      = 2;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic RTS_IDLE_PIN = 1'h1;
   localparam logic DTR_IDLE_PIN = 1'h1;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {
      UBSC_UNCONF,
      UBSC_ACTIVE,
      UBSC_SUSP
   } ubsc_state_t;

   // modem inputs, raw active-low pin levels
   typedef struct packed {
      logic cts_n;
      logic dsr_n;
      logic dcd_n;
      logic ri_n;
   } ubsc_modem_in_t;

   // modem status as true (active-high) levels
   typedef struct packed {
      logic cts;
      logic dsr;
      logic dcd;
      logic ri;
   } ubsc_modem_stat_t;

   // host-side bus events, one-cycle pulses from the usb core
   typedef struct packed {
      logic suspend_det;
      logic resume_det;
      logic resume_gen;
      logic bus_reset;
      logic configured;
   } ubsc_usb_evt_t;

endpackage : ubsc_pkg

//--- src/ubsc_rst_filt.sv
// Purpose: qualifies the external reset pin level and registers the power-on request to pull the pin low
// Assumes: pin input is synchronous to the clock
// Notes:   a low pin must persist for the full minimum before a reset is issued
module ubsc_rst_filt
   import ubsc_pkg::*;
#(
   parameter int unsigned MIN_CYC = EXT_RST_MIN_CYC
)(
   input  wire logic I_SYS_CLK,
   input  wire logic I_RSTN,
   input  wire logic i_pin_lvl,
   input  wire logic i_por,
   output logic      o_ext_rst,
   output logic      o_drive_low
);
   if (MIN_CYC < 1 || MIN_CYC >= (1 << RST_CNT_W))
   begin : g_bad_min_cyc
      $error("ubsc_rst_filt: MIN_CYC out of range");
   end

   logic [RST_CNT_W-1:0] cnt_q;

   // count consecutive low cycles; short glitches never reach the core
   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RSTN)
         cnt_q <= '0;
      else if (i_pin_lvl)
         cnt_q <= '0;
      else if (cnt_q != RST_CNT_W'(MIN_CYC))
         cnt_q <= cnt_q + RST_CNT_W'(1);
   end

   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RSTN)
         o_ext_rst <= 1'b0;
      else
         // the sample that completes the minimum low time already counts
         o_ext_rst <= !i_pin_lvl && (cnt_q >= RST_CNT_W'(MIN_CYC - 1));
   end

   // open drain: only ever pulls low, never drives high
   always_ff @(posedge I_SYS_CLK)
   begin
      if (!I_RSTN)
         o_drive_low <= 1'b0;
      else
         o_drive_low <= i_por;
   end

   property p_ext_rst_min;
      @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      $rose(o_ext_rst) |-> $past(!i_pin_lvl) && ($past(cnt_q) >= RST_CNT_W'(MIN_CYC - 1));
   endproperty
   a_ext_rst_min: assert property (p_ext_rst_min)
      else $error("external reset issued without a held-low pin");

endmodule // ubsc_rst_filt

//--- dv/ubsc_far_mdl.sv
// Purpose: far side of the bridge pins: reset net and suspend indicator nets
// Assumes: pull-ups on the reset net and on both indicator nets
// Notes:   a released net reads high, never the last driven value
module ubsc_far_mdl
(
   input  wire logic i_rst_oe,
   input  wire logic i_ext_pull,
   input  wire logic i_susp,
   input  wire logic i_susp_oe,
   input  wire logic i_susp_n,
   input  wire logic i_susp_n_oe,
   output logic      o_rst_wire,
   output logic      o_susp_wire,
   output logic      o_susp_n_wire
);
   timeunit 1ns;
   timeprecision 1ps;

   // ************************************************************
   // wired nets
   // ************************************************************
   // open drain: any party pulling wins over the pull-up
   assign o_rst_wire    = !(i_rst_oe || i_ext_pull);
   // floating indicators drift high through the pull-ups
   assign o_susp_wire   = i_susp_oe ? i_susp : 1'b1;
   assign o_susp_n_wire = i_susp_n_oe ? i_susp_n : 1'b1;
endmodule // ubsc_far_mdl

//--- dv/usb_bridge_suspend_control_tb_top.sv
// Purpose: self-checking bench for suspend, reset pin and modem pin control
// Assumes: reset count shortened to 4 cycles
// Notes:   usb events come as one-cycle pulses, as the usb core gives them
module usb_bridge_suspend_control_tb_top
   import ubsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ************************************************************
   // signals
   // ************************************************************
   localparam int unsigned   RST_CYC = 4;
   localparam ubsc_usb_evt_t EV_SUS  = 5'h10;
   localparam ubsc_usb_evt_t EV_RSM  = 5'h08;
   localparam ubsc_usb_evt_t EV_RGN  = 5'h04;
   localparam ubsc_usb_evt_t EV_BRS  = 5'h02;
   localparam ubsc_usb_evt_t EV_CFG  = 5'h01;

   logic             sys_clk = 1'b0;
   logic             rstn, por, vbus, rts_req, dtr_req, ext_pull;
   logic             rst_wire, susp_wire, susp_n_wire;
   ubsc_usb_evt_t    evt;
   ubsc_modem_in_t   modem;
   ubsc_modem_stat_t stat;
   logic             o_rst_pin, o_rst_oe, o_susp, o_susp_oe, o_susp_n, o_susp_n_oe;
   logic             o_rts_n, o_dtr_n, o_vbus, o_dev_rst;
   int               fails, check_count;

   always #4 sys_clk = ~sys_clk;

   ubsc_top #(.EXT_RST_CYC(RST_CYC)) uut (
      .I_SYS_CLK(sys_clk), .I_RSTN(rstn), .I_RST_PIN(rst_wire), .I_POR(por),
      .I_VBUS(vbus), .I_USB_EVT(evt), .I_MODEM(modem), .I_RTS_REQ(rts_req),
      .I_DTR_REQ(dtr_req), .O_RST_PIN(o_rst_pin), .O_RST_PIN_OE(o_rst_oe),
      .O_SUSP(o_susp), .O_SUSP_OE(o_susp_oe), .O_SUSP_N(o_susp_n),
      .O_SUSP_N_OE(o_susp_n_oe), .O_RTS_N(o_rts_n), .O_DTR_N(o_dtr_n),
      .O_VBUS_ATTACHED(o_vbus), .O_DEV_RST(o_dev_rst), .O_MODEM_STAT(stat));

   ubsc_far_mdl far (
      .i_rst_oe(o_rst_oe), .i_ext_pull(ext_pull), .i_susp(o_susp),
      .i_susp_oe(o_susp_oe), .i_susp_n(o_susp_n), .i_susp_n_oe(o_susp_n_oe),
      .o_rst_wire(rst_wire), .o_susp_wire(susp_wire), .o_susp_n_wire(susp_n_wire));

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   task automatic summarize();
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic ev(input ubsc_usb_evt_t e);
      @(posedge sys_clk);
      evt <= e;
      @(posedge sys_clk);
      evt <= '0;
      cyc(1);
   endtask

   // driven indicators, complementary
   task automatic ind(input logic s, input string m);
      chk({o_susp_oe, o_susp_n_oe, o_susp, o_susp_n}, {2'h3, s, !s}, m);
   endtask

   // bounded wait; running out ends the run
   task automatic wait_rst(input logic lvl);
      int n;
      for (n = 0; n < 20 && o_dev_rst !== lvl; n++)
         cyc(1);
      if (n == 20)
      begin
         fails++;
         summarize();
      end
      cyc(1);
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_start();
      cyc(1);
      ind(1'b1, "indicators after reset");
      chk({o_rts_n, o_dtr_n}, 2'h3, "modem outputs idle");
      ev(EV_SUS);
      ind(1'b1, "suspend before configuration");
      $display("t_start done");
   endtask

   task automatic t_suspend();
      ev(EV_CFG);
      ind(1'b0, "configured");
      ev(EV_SUS);
      ind(1'b1, "suspend entry");
      ev(EV_RSM);
      ind(1'b0, "resume detected");
      ev(EV_SUS);
      ev(EV_RGN);
      ind(1'b0, "resume generated");
      ev(ubsc_usb_evt_t'(EV_SUS | EV_RSM));
      ind(1'b0, "suspend with resume");
      ev(EV_SUS);
      ev(EV_BRS);
      ind(1'b0, "bus reset leaves suspend");
      ev(EV_BRS);
      ind(1'b1, "bus reset while active");
      ev(EV_CFG);
      ind(1'b0, "configured again");
      $display("t_suspend done");
   endtask

   task automatic t_modem();
      for (int i = 0; i < 4; i++)
      begin
         @(posedge sys_clk);
         modem   <= ubsc_modem_in_t'(4'hF ^ (4'h1 << i));
         rts_req <= i[0];
         dtr_req <= i[1];
         vbus    <= i[0];
         cyc(2);
         chk(stat, 4'h1 << i, "modem status");
         chk({o_rts_n, o_dtr_n}, {!i[0], !i[1]}, "rts dtr");
         chk(o_vbus, i[0], "vbus sense");
      end
      @(posedge sys_clk);
      modem <= 4'hF;
      $display("t_modem done");
   endtask

   task automatic t_ext_rst();
      @(posedge sys_clk);
      ext_pull <= 1'b1;
      repeat (RST_CYC - 1) @(posedge sys_clk);
      ext_pull <= 1'b0;
      cyc(8);
      chk(o_dev_rst, 1'b0, "short low ignored");
      ind(1'b0, "short low keeps state");
      @(posedge sys_clk);
      ext_pull <= 1'b1;
      wait_rst(1'b1);
      chk({o_susp_oe, o_susp_n_oe, susp_wire, susp_n_wire}, 4'h3, "float");
      chk(o_rst_oe, 1'b0, "no drive on outside reset");
      @(posedge sys_clk);
      ext_pull <= 1'b0;
      wait_rst(1'b0);
      cyc(2);
      ind(1'b1, "asserted after device reset");
      ev(EV_CFG);
      ind(1'b0, "configured after device reset");
      $display("t_ext_rst done");
   endtask

   task automatic t_por();
      ev(EV_SUS);
      ind(1'b1, "suspended before power-on reset");
      @(posedge sys_clk);
      por <= 1'b1;
      wait_rst(1'b1);
      chk({o_rst_pin, o_rst_oe, rst_wire}, 3'h2, "reset pin pulled");
      chk({o_susp_oe, o_susp_n_oe}, 2'h0, "float on por");
      @(posedge sys_clk);
      por <= 1'b0;
      wait_rst(1'b0);
      cyc(2);
      chk({o_rst_oe, rst_wire}, 2'h1, "reset pin released");
      ind(1'b1, "unconfigured after por");
      $display("t_por done");
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      {rstn, por, vbus, rts_req, dtr_req, ext_pull} = 6'h00;
      evt = '0;
      modem = 4'hF;
      fails = 0;
      check_count = 0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      t_start();
      t_suspend();
      t_modem();
      t_ext_rst();
      t_por();
      summarize();
   end
endmodule // usb_bridge_suspend_control_tb_top
